// ===== design/tsar_defs.vh
// Constants for the sensor address and register-selector block
`ifndef TSAR_DEFS_VH
`define TSAR_DEFS_VH

// =====================================================
// Register selector codes
`define TSAR_SEL_TEMP 3'h0
`define TSAR_SEL_CONF 3'h1
`define TSAR_SEL_HYST 3'h2
`define TSAR_SEL_OVER 3'h3
`define TSAR_SEL_IDLE 3'h4

// =====================================================
// Power-on values
`define TSAR_RST_TEMP 16'h0000
`define TSAR_RST_CONF 8'h00
`define TSAR_RST_HYST 16'h4b00
`define TSAR_RST_OVER 16'h5000
`define TSAR_RST_IDLE 8'h00
`define TSAR_RST_SEL 3'h0

// =====================================================
// Configuration fields
`define TSAR_CONF_SHDN 0
`define TSAR_CONF_MODE 1
`define TSAR_CONF_POL 2
`define TSAR_CONF_FQ_LO 3
`define TSAR_CONF_FQ_HI 4

// =====================================================
// Fault queue depths
`define TSAR_FQ_00 3'h1
`define TSAR_FQ_01 3'h2
`define TSAR_FQ_10 3'h4
`define TSAR_FQ_11 3'h6

// =====================================================
// Address pin levels (bit1 floating, bit0 logic value)
`define TSAR_LVL_FLT_BIT 1
`define TSAR_ADDR_BASE_FIXED 4'h9
`define TSAR_ADDR_BASE_HFLT 4'he
`define TSAR_ADDR_BASE_MIX 4'h5
`define TSAR_ADDR_BASE_DUAL 4'h6
`define TSAR_ADDR_SIX_LOW 7'h48
`define TSAR_ADDR_SIX_FLT 7'h49
`define TSAR_ADDR_SIX_HIGH 7'h4a
`define TSAR_ADDR_ALL_FLT 7'h37

// =====================================================
// Strap capture delay after reset release, in cycles
`define TSAR_CAP_DELAY 2'h2

`endif

// ===== design/tsar_regs.v
// Sensor slave address decode, serial register access and alarm logic
`timescale 1ns/100ps
`include "tsar_defs.vh"
// Overview of operation
// - Address pins sampled once after reset, latched
// - Each address pin decodes zero, one, floating
// - No floating pins: address 1001 plus pins
// - High floating: 1110 plus pair index; all three floating give 37h
// - Mixed floating pins map to 0101/0110 codes
// - Six-pin variant: single pin picks three addresses
// - Selector low three bits choose five registers
// - Selector unreadable, changes only on selector byte
// - Read without selector returns last selected register
// - Selector resets to temperature register
// - Temperature register read-only, resets zero
// - Overtemperature limit read/write, resets 5000h
// - Hysteresis limit read/write, resets 4B00h
// - Idle period read/write, resets 00h
// - Configuration byte read/write, resets 00h
// - Bits 4:3 pick fault count 1,2,4,6
// - Bit 2 sets alarm polarity
// - Bit 1 selects comparator or interrupt
// - Bit 0 selects shutdown
// - Shutdown stops conversions, keeps result, bus works
// - Comparator: assert above limit, release below hysteresis
// - Interrupt alarm cleared by read or shutdown
// - Alarm needs programmed consecutive fault count
module tsar_regs #(
  parameter SIX_PIN = 0
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Address straps: {floating, value}
  input wire [1:0] addr_pin_low,
  input wire [1:0] addr_pin_mid,
  input wire [1:0] addr_pin_high,
  // Serial bus pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  // Open-drain alarm pin
  output wire alarm_output_out,
  output reg alarm_output_oe,
  // Converter side
  input wire [10:0] temp_sample,
  input wire temp_valid,
  output reg conversion_enable,
  output reg [7:0] idle_period_out,
  output reg [6:0] slave_addr_out
);

  // =====================================================
  // States
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_RX = 3'd3;
  localparam ST_TX = 3'd4;
  localparam ST_TXACK = 3'd5;

  // =====================================================
  // Functions
  function [6:0] tsar_decode;
    input [1:0] h;
    input [1:0] m;
    input [1:0] l;
    reg fh;
    reg fm;
    reg fl;
    begin
      fh = h[`TSAR_LVL_FLT_BIT];
      fm = m[`TSAR_LVL_FLT_BIT];
      fl = l[`TSAR_LVL_FLT_BIT];
      if (SIX_PIN != 0) begin
        if (fl)
          tsar_decode = `TSAR_ADDR_SIX_FLT;
        else if (l[0])
          tsar_decode = `TSAR_ADDR_SIX_HIGH;
        else
          tsar_decode = `TSAR_ADDR_SIX_LOW;
      end else if (!fh && !fm && !fl) begin
        tsar_decode = {`TSAR_ADDR_BASE_FIXED, h[0], m[0], l[0]};
      end else if (fh) begin
        if (fm && fl)
          tsar_decode = `TSAR_ADDR_ALL_FLT;
        else if (fm)
          tsar_decode = {`TSAR_ADDR_BASE_HFLT, 2'b11, l[0]};
        else if (m[0])
          tsar_decode = {`TSAR_ADDR_BASE_HFLT, fl ? 3'd4 : (l[0] ? 3'd5 : 3'd3)};
        else
          tsar_decode = {`TSAR_ADDR_BASE_HFLT, fl ? 3'd1 : (l[0] ? 3'd2 : 3'd0)};
      end else if (fm && fl) begin
        tsar_decode = {`TSAR_ADDR_BASE_DUAL, 1'b1, h[0], ~h[0]};
      end else if (fm) begin
        tsar_decode = {`TSAR_ADDR_BASE_MIX, 1'b0, h[0], l[0]};
      end else begin
        tsar_decode = {`TSAR_ADDR_BASE_MIX, 1'b1, h[0], m[0]};
      end
    end
  endfunction

  function [2:0] tsar_queue;
    input [1:0] code;
    begin
      case (code)
        2'b00: tsar_queue = `TSAR_FQ_00;
        2'b01: tsar_queue = `TSAR_FQ_01;
        2'b10: tsar_queue = `TSAR_FQ_10;
        default: tsar_queue = `TSAR_FQ_11;
      endcase
    end
  endfunction

  // =====================================================
  // Synchronisers
  reg [1:0] pl_s1;
  reg [1:0] pl_s2;
  reg [1:0] pm_s1;
  reg [1:0] pm_s2;
  reg [1:0] ph_s1;
  reg [1:0] ph_s2;
  reg scl_s1;
  reg scl_s2;
  reg scl_d;
  reg sda_s1;
  reg sda_s2;
  reg sda_d;

  always @(posedge clk) begin
    if (ce) begin
      pl_s1 <= addr_pin_low;
      pl_s2 <= pl_s1;
      pm_s1 <= addr_pin_mid;
      pm_s2 <= pm_s1;
      ph_s1 <= addr_pin_high;
      ph_s2 <= ph_s1;
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // =====================================================
  // Registers and bus engine
  reg [1:0] cap_cnt_reg;
  reg addr_done_reg;
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] rx_shift_reg;
  reg [7:0] tx_shift_reg;
  reg [1:0] byte_idx_reg;
  reg rd_idx_reg;
  reg rw_reg;
  reg nack_reg;
  reg [2:0] sel_reg;
  reg [15:0] snap_reg;
  reg [7:0] wr_msb_reg;
  reg [15:0] temp_reg;
  reg [7:0] conf_reg;
  reg [15:0] hyst_reg;
  reg [15:0] over_reg;
  reg read_clear;
  reg shdn_entry;
  reg [15:0] sel_word;

  assign sda_out = 1'b0;

  always @* begin
    case (sel_reg)
      `TSAR_SEL_TEMP: sel_word = temp_reg;
      `TSAR_SEL_CONF: sel_word = {conf_reg, 8'h00};
      `TSAR_SEL_HYST: sel_word = hyst_reg;
      `TSAR_SEL_OVER: sel_word = over_reg;
      `TSAR_SEL_IDLE: sel_word = {idle_period_out, 8'h00};
      default: sel_word = 16'h0000;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      cap_cnt_reg <= 2'h0;
      addr_done_reg <= 1'b0;
      slave_addr_out <= 7'h00;
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      rd_idx_reg <= 1'b0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe <= 1'b0;
      sel_reg <= `TSAR_RST_SEL;
      snap_reg <= 16'h0000;
      wr_msb_reg <= 8'h00;
      temp_reg <= `TSAR_RST_TEMP;
      conf_reg <= `TSAR_RST_CONF;
      hyst_reg <= `TSAR_RST_HYST;
      over_reg <= `TSAR_RST_OVER;
      idle_period_out <= `TSAR_RST_IDLE;
      read_clear <= 1'b0;
      shdn_entry <= 1'b0;
    end else if (ce) begin
      read_clear <= 1'b0;
      shdn_entry <= 1'b0;
      // Wait for the synchronisers to fill before taking the straps
      if (!addr_done_reg) begin
        if (cap_cnt_reg == `TSAR_CAP_DELAY) begin
          addr_done_reg <= 1'b1;
          slave_addr_out <= tsar_decode(ph_s2, pm_s2, pl_s2);
        end else begin
          cap_cnt_reg <= cap_cnt_reg + 2'h1;
        end
      end
      // Results held while shut down
      if (temp_valid && !conf_reg[`TSAR_CONF_SHDN])
        temp_reg <= {temp_sample, 5'h00};
      if (bus_stop) begin
        state_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state_reg == ST_ADDR || state_reg == ST_RX) begin
          rx_shift_reg <= {rx_shift_reg[6:0], sda_s2};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (state_reg == ST_TXACK)
          nack_reg <= sda_s2;
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (addr_done_reg && rx_shift_reg[7:1] == slave_addr_out) begin
                state_reg <= ST_ACK;
                sda_oe <= 1'b1;
                rw_reg <= rx_shift_reg[0];
                byte_idx_reg <= 2'h0;
                rd_idx_reg <= 1'b0;
                if (rx_shift_reg[0]) begin
                  snap_reg <= sel_word;
                  read_clear <= 1'b1;
                end
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_RX: begin
            if (bit_cnt_reg == 4'h8) begin
              state_reg <= ST_ACK;
              sda_oe <= 1'b1;
              if (byte_idx_reg != 2'h3)
                byte_idx_reg <= byte_idx_reg + 2'h1;
              if (byte_idx_reg == 2'h0) begin
                sel_reg <= rx_shift_reg[2:0];
              end else if (byte_idx_reg == 2'h1) begin
                wr_msb_reg <= rx_shift_reg;
                if (sel_reg == `TSAR_SEL_CONF) begin
                  conf_reg <= rx_shift_reg;
                  if (rx_shift_reg[`TSAR_CONF_SHDN] && !conf_reg[`TSAR_CONF_SHDN])
                    shdn_entry <= 1'b1;
                end
                if (sel_reg == `TSAR_SEL_IDLE)
                  idle_period_out <= rx_shift_reg;
              end else if (byte_idx_reg == 2'h2) begin
                if (sel_reg == `TSAR_SEL_HYST)
                  hyst_reg <= {wr_msb_reg, rx_shift_reg};
                if (sel_reg == `TSAR_SEL_OVER)
                  over_reg <= {wr_msb_reg, rx_shift_reg};
              end
            end
          end
          ST_ACK: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg <= ST_TX;
              tx_shift_reg <= {snap_reg[14:8], 1'b0};
              sda_oe <= ~snap_reg[15];
              rd_idx_reg <= 1'b1;
            end else begin
              state_reg <= ST_RX;
              sda_oe <= 1'b0;
            end
          end
          ST_TX: begin
            if (bit_cnt_reg == 4'h7) begin
              state_reg <= ST_TXACK;
              sda_oe <= 1'b0;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              sda_oe <= ~tx_shift_reg[7];
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
          end
          ST_TXACK: begin
            bit_cnt_reg <= 4'h0;
            if (nack_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              // Byte pairs repeat MSB, LSB while the master keeps acking
              state_reg <= ST_TX;
              rd_idx_reg <= ~rd_idx_reg;
              if (rd_idx_reg) begin
                sda_oe <= ~snap_reg[7];
                tx_shift_reg <= {snap_reg[6:0], 1'b0};
              end else begin
                sda_oe <= ~snap_reg[15];
                tx_shift_reg <= {snap_reg[14:8], 1'b0};
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // =====================================================
  // Alarm engine
  reg alarm_reg;
  reg arm_low_reg;
  reg [2:0] fault_cnt_reg;
  wire signed [8:0] temp9 = temp_sample[10:2];
  wire signed [8:0] over9 = over_reg[15:7];
  wire signed [8:0] hyst9 = hyst_reg[15:7];
  wire hi_trip = temp9 > over9;
  wire lo_trip = temp9 < hyst9;
  wire int_mode = conf_reg[`TSAR_CONF_MODE];
  wire conv_ok = temp_valid & ~conf_reg[`TSAR_CONF_SHDN];
  wire want_low = int_mode ? arm_low_reg : alarm_reg;
  wire fault = want_low ? lo_trip : hi_trip;
  wire [2:0] fault_inc = fault_cnt_reg + 3'h1;
  wire [2:0] fault_need = tsar_queue(conf_reg[`TSAR_CONF_FQ_HI:`TSAR_CONF_FQ_LO]);
  wire alarm_event = conv_ok & fault & (fault_inc >= fault_need);

  assign alarm_output_out = 1'b0;

  always @(posedge clk) begin
    if (!rst_n) begin
      alarm_reg <= 1'b0;
      arm_low_reg <= 1'b0;
      fault_cnt_reg <= 3'h0;
      alarm_output_oe <= 1'b0;
      conversion_enable <= 1'b0;
    end else if (ce) begin
      conversion_enable <= ~conf_reg[`TSAR_CONF_SHDN];
      // Pin pulled low when active-low alarm is set or active-high is idle
      alarm_output_oe <= alarm_reg ^ conf_reg[`TSAR_CONF_POL];
      if (conv_ok)
        fault_cnt_reg <= (fault && !alarm_event) ? fault_inc : 3'h0;
      if (int_mode && (read_clear || shdn_entry))
        alarm_reg <= 1'b0;
      // Event written last so it wins over a same-cycle clear
      if (alarm_event) begin
        if (int_mode) begin
          alarm_reg <= 1'b1;
          arm_low_reg <= ~arm_low_reg;
        end else begin
          alarm_reg <= ~alarm_reg;
        end
      end
    end
  end

endmodule

// ===== verif/tsar_regs_properties.sv
// Port checker for the sensor address and register block
`timescale 1ns/100ps
module tsar_regs_properties #(
  parameter SIX_PIN = 0
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Straps and bus
  input wire [1:0] addr_pin_low,
  input wire [1:0] addr_pin_mid,
  input wire [1:0] addr_pin_high,
  input wire scl_in,
  input wire sda_oe,
  // Alarm and converter
  input wire alarm_output_oe,
  input wire [10:0] temp_sample,
  input wire temp_valid,
  input wire conversion_enable,
  input wire [7:0] idle_period_out,
  input wire [6:0] slave_addr_out
);
  // ==========
  // Helpers
  wire [5:0] sp = {addr_pin_high, addr_pin_mid, addr_pin_low};
  wire fix = SIX_PIN == 0 && !sp[5] && !sp[3] && !sp[1];
  wire flt = SIX_PIN == 0 && sp[5] && sp[3] && sp[1];
  wire signed [8:0] t9 = temp_sample[10:2];
  reg quiet_reg;
  // Power-on limits are only known until the bus is first used
  always @(posedge clk) begin
    if (!rst_n)
      quiet_reg <= 1'b1;
    else if (!scl_in)
      quiet_reg <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Assertions
  AST_ADDR_HOLD: assert property (
    slave_addr_out != 7'h00 |=> $stable(slave_addr_out))
    else $error("slave address changed after capture");
  AST_ADDR_FIXED: assert property (
    $rose(rst_n) && fix |-> ##6 slave_addr_out == {4'h9, sp[4], sp[2], sp[0]})
    else $error("fixed strap address wrong");
  AST_ADDR_ALLFLT: assert property (
    $rose(rst_n) && flt |-> ##6 slave_addr_out == 7'h37)
    else $error("floating strap address wrong");
  AST_CONV_RST: assert property (
    $rose(rst_n) |-> ##2 conversion_enable)
    else $error("conversion not running after reset");
  AST_RST_OUTS: assert property (
    $rose(rst_n) |-> idle_period_out == 8'h00 && !alarm_output_oe)
    else $error("outputs wrong after reset");
  AST_HOT: assert property (
    quiet_reg && temp_valid && t9 > 9'sh0a0 |-> ##[1:2] alarm_output_oe)
    else $error("alarm not raised above limit");
  AST_COOL: assert property (
    quiet_reg && temp_valid && t9 < 9'sh096 |-> ##[1:2] !alarm_output_oe)
    else $error("alarm not released below hysteresis");
  AST_SDA_PHASE: assert property (
    $changed(sda_oe) |-> !scl_in)
    else $error("data line moved while bus clock high");
  cover property (quiet_reg && temp_valid && t9 > 9'sh0a0);
  cover property ($rose(sda_oe));
  cover property ($fell(conversion_enable));
endmodule
bind tsar_regs tsar_regs_properties #(.SIX_PIN(SIX_PIN)) tsar_regs_properties_inst (
  .clk(clk), .rst_n(rst_n), .addr_pin_low(addr_pin_low), .addr_pin_mid(addr_pin_mid),
  .addr_pin_high(addr_pin_high), .scl_in(scl_in), .sda_oe(sda_oe),
  .alarm_output_oe(alarm_output_oe), .temp_sample(temp_sample), .temp_valid(temp_valid),
  .conversion_enable(conversion_enable), .idle_period_out(idle_period_out),
  .slave_addr_out(slave_addr_out));

// ===== verif/tsar_bus_master.sv
// Two-wire bus master model facing the sensor
`timescale 1ns/100ps
module tsar_bus_master (
  // Clock
  input wire clk,
  // Bus wires
  output reg scl,
  output reg sda_low,
  input wire sda
);
  integer hp;
  initial begin
    hp = 16;
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task wt;
    repeat (hp) @(posedge clk);
  endtask
  task start_c;
    begin
      sda_low <= 1'b1;
      wt;
      scl <= 1'b0;
    end
  endtask
  // Data moves two edges after the fall so no false start or stop is seen
  task bit_x(input b, output r);
    begin
      repeat (2) @(posedge clk);
      sda_low <= ~b;
      wt;
      scl <= 1'b1;
      wt;
      r = sda;
      scl <= 1'b0;
    end
  endtask
  task stop_c;
    begin
      repeat (2) @(posedge clk);
      sda_low <= 1'b1;
      wt;
      scl <= 1'b1;
      wt;
      sda_low <= 1'b0;
      wt;
    end
  endtask
  // Eight data slots, then the acknowledge slot
  task byte_x(input [8:0] d, output [8:0] q);
    integer i;
    for (i = 8; i >= 0; i = i - 1)
      bit_x(d[i], q[i]);
  endtask
endmodule

// ===== verif/tsar_regs_tb.sv
// Self-checking bench for the sensor address and register block
`timescale 1ns/100ps
module tsar_regs_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [5:0] straps = 6'h00;
  reg [10:0] smp = 11'h000;
  reg vld = 1'b0;
  wire scl, m_low, sda_oe, al_oe, conv_en;
  wire [7:0] idle_o;
  wire [6:0] saddr;
  // Pulled-up open-drain data wire
  wire sda_w = ~(m_low | sda_oe);
  integer err_total = 0;
  integer n_compared = 0;
  reg [8:0] q;
  reg [15:0] rv;
  always #4 clk = ~clk;
  tsar_regs tsar_regs_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .addr_pin_low(straps[1:0]), .addr_pin_mid(straps[3:2]), .addr_pin_high(straps[5:4]),
    .scl_in(scl), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .alarm_output_out(),
    .alarm_output_oe(al_oe), .temp_sample(smp), .temp_valid(vld),
    .conversion_enable(conv_en), .idle_period_out(idle_o), .slave_addr_out(saddr));
  tsar_bus_master tsar_bus_master_inst (.clk(clk), .scl(scl), .sda_low(m_low), .sda(sda_w));
  // ==========
  // Shared tasks
  task cmp(input [15:0] e, input [15:0] g, input [63:0] nm);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("wrong value %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task ca(input e);
    cmp({15'h0000, e}, {15'h0000, al_oe}, "alarm");
  endtask
  task rst;
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask
  task pulse(input [10:0] s);
    begin
      @(posedge clk);
      smp <= s;
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task wr(input [2:0] sel, input integer n, input [15:0] d);
    begin
      tsar_bus_master_inst.start_c;
      tsar_bus_master_inst.byte_x({8'h90, 1'b1}, q);
      tsar_bus_master_inst.byte_x({5'h00, sel, 1'b1}, q);
      if (n > 0) tsar_bus_master_inst.byte_x({d[15:8], 1'b1}, q);
      if (n > 1) tsar_bus_master_inst.byte_x({d[7:0], 1'b1}, q);
      tsar_bus_master_inst.stop_c;
    end
  endtask
  task rd(input [2:0] sel, input s, output [15:0] d);
    begin
      if (s) wr(sel, 0, 16'h0000);
      tsar_bus_master_inst.start_c;
      tsar_bus_master_inst.byte_x({8'h91, 1'b1}, q);
      tsar_bus_master_inst.byte_x({8'hff, 1'b0}, q);
      d[15:8] = q[8:1];
      tsar_bus_master_inst.byte_x({8'hff, 1'b1}, q);
      d[7:0] = q[8:1];
      tsar_bus_master_inst.stop_c;
    end
  endtask
  // ==========
  // Scenarios
  task t_straps;
    reg [12:0] t [0:6];
    integer i;
    begin
      t[0] = {6'h15, 7'h4f};
      t[1] = {6'h22, 7'h71};
      t[2] = {6'h09, 7'h29};
      t[3] = {6'h16, 7'h2f};
      t[4] = {6'h0a, 7'h35};
      t[5] = {6'h2a, 7'h37};
      t[6] = {6'h00, 7'h48};
      for (i = 0; i < 7; i = i + 1) begin
        straps <= t[i][12:7];
        rst;
        cmp({9'h000, t[i][6:0]}, {9'h000, saddr}, "addr");
        straps <= ~t[i][12:7];
        repeat (8) @(posedge clk);
        cmp({9'h000, t[i][6:0]}, {9'h000, saddr}, "latched");
      end
      $display("t_straps done");
    end
  endtask
  task t_regs;
    reg [18:0] e [0:4];
    integer i;
    begin
      e[0] = {3'h0, 16'h0000};
      e[1] = {3'h1, 16'h0000};
      e[2] = {3'h2, 16'h4b00};
      e[3] = {3'h3, 16'h5000};
      e[4] = {3'h4, 16'h0000};
      rd(3'h0, 1'b0, rv);
      cmp(16'h0000, rv, "temp");
      for (i = 4; i >= 0; i = i - 1) begin
        rd(e[i][18:16], 1'b1, rv);
        cmp(e[i][15:0], rv, "por");
      end
      $display("t_regs done");
    end
  endtask
  task t_rw;
    begin
      wr(3'h3, 2, 16'h5500);
      wr(3'h1, 1, 16'h1a00);
      wr(3'h4, 1, 16'h1f00);
      cmp(16'h001f, {8'h00, idle_o}, "idle");
      rd(3'h3, 1'b1, rv);
      cmp(16'h5500, rv, "over");
      rd(3'h3, 1'b0, rv);
      cmp(16'h5500, rv, "reread");
      rd(3'h1, 1'b1, rv);
      cmp(16'h1a00, rv, "conf");
      wr(3'h0, 2, 16'h1234);
      rd(3'h0, 1'b0, rv);
      cmp(16'h0000, rv, "temp");
      wr(3'h1, 1, 16'h0100);
      cmp(16'h0000, {15'h0000, conv_en}, "conv");
      wr(3'h1, 1, 16'h0000);
      $display("t_rw done");
    end
  endtask
  task t_nack;
    begin
      tsar_bus_master_inst.hp = 40;
      tsar_bus_master_inst.start_c;
      tsar_bus_master_inst.byte_x({8'h92, 1'b1}, q);
      tsar_bus_master_inst.stop_c;
      cmp(16'h0001, {15'h0000, q[0]}, "nack");
      tsar_bus_master_inst.start_c;
      tsar_bus_master_inst.byte_x({8'h90, 1'b1}, q);
      tsar_bus_master_inst.stop_c;
      cmp(16'h0000, {15'h0000, q[0]}, "ack");
      tsar_bus_master_inst.hp = 16;
      $display("t_nack done");
    end
  endtask
  task t_alarm;
    begin
      straps <= 6'h00;
      rst;
      pulse(11'h284);
      ca(1'b1);
      pulse(11'h26c);
      ca(1'b1);
      pulse(11'h254);
      ca(1'b0);
      wr(3'h1, 1, 16'h0800);
      pulse(11'h284);
      ca(1'b0);
      pulse(11'h284);
      ca(1'b1);
      wr(3'h1, 1, 16'h0c00);
      ca(1'b0);
      wr(3'h1, 1, 16'h0200);
      rd(3'h0, 1'b1, rv);
      cmp(16'h5080, rv, "temp");
      ca(1'b0);
      pulse(11'h284);
      pulse(11'h254);
      ca(1'b1);
      wr(3'h1, 1, 16'h0300);
      ca(1'b0);
      cmp(16'h0000, {15'h0000, conv_en}, "conv");
      pulse(11'h200);
      rd(3'h0, 1'b1, rv);
      cmp(16'h4a80, rv, "hold");
      $display("t_alarm done");
    end
  endtask
  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Run needs about 30k cycles; give up at 75k
  initial begin
    #600000;
    err_total = err_total + 1;
    finish_test;
  end
  initial begin
    t_straps;
    t_regs;
    t_rw;
    t_nack;
    t_alarm;
    finish_test;
  end
endmodule
